/* src/pgcr_top.sv */
`timescale 1ns/10ps
// Contract
// - global registers answer only while page select holds 0x0010, and 0x0000 returns to main page.
// - writing the command window with bit 15 set makes the engine run the encoded command.
// - bit 15 reads 1 while the command runs and is cleared by the engine when it ends.
// - command 0x80B0 sets all twelve ports to SGMII and 0x80A0 sets them to QSGMII.
// - command 0x8F81 sets ports 8 to 11 to 1000BASE-X and 0x8F91 sets them to 100BASE-FX.
// - each bit of bits 11:8 of a media command picks one upper port, and a 0 leaves it untouched.
// - mac mode bits 15:14 default 00; 00 and 10 are QSGMII, 01 is SGMII, 11 is reserved.
// - fast link select bits 3:0 route port 0 to 11 to the fast link pin, 12 to 15 disable it, reset 0xF.
// - led duty bits 15:8 act only with pulsing enabled, 0 is 0.5 percent, 198 is 99.5 percent.
// - led control bit 7 turns pins 5 to 8 into serial led outputs, default off.
// - led control bit 6 turns pins 3 to 0 into serial led outputs, default off.
// - frame rate bits 5:3 pick 2500, 1000, 500, 250, 200, 125 or 40 Hz, code 111 is reserved.
// - led select bits 2:1 put four, three, two or one leds of each port in the stream, default 00.
// - port source bits 11:0 read 0 for a port that raised the shared interrupt, else 1.
// - reading a port's own interrupt status returns its source bit to 1.
module pgcr_top
	import pgcr_pkg::*;
#(
	parameter int unsigned FRAME_CYC_0 = CLK_HZ / FRAME_HZ_0,
	parameter int unsigned FRAME_CYC_1 = CLK_HZ / FRAME_HZ_1,
	parameter int unsigned FRAME_CYC_2 = CLK_HZ / FRAME_HZ_2,
	parameter int unsigned FRAME_CYC_3 = CLK_HZ / FRAME_HZ_3,
	parameter int unsigned FRAME_CYC_4 = CLK_HZ / FRAME_HZ_4,
	parameter int unsigned FRAME_CYC_5 = CLK_HZ / FRAME_HZ_5,
	parameter int unsigned FRAME_CYC_6 = CLK_HZ / FRAME_HZ_6
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic [3:0]           wb_sel_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic [NUM_PORTS-1:0] port_irq_i,
	input  wire logic [NUM_PORTS-1:0] port_stat_rd_i,
	input  wire logic [NUM_PORTS-1:0] link_fail_i,
	input  wire logic                 led_pulse_en_i,
	output logic                      mac_sgmii_o,
	output logic                      mac_mode_rsvd_o,
	output logic      [NUM_MEDIA-1:0] media_1000x_o,
	output logic      [NUM_MEDIA-1:0] media_100fx_o,
	output logic                      fast_link_o,
	output logic                      fast_link_en_o,
	output logic                      led_pins_hi_en_o,
	output logic                      led_pins_lo_en_o,
	output logic      [2:0]           led_per_port_o,
	output logic                      led_frame_tick_o,
	output logic                      led_pwm_o,
	output logic                      irq_o
);

	// decode helper: 3-bit frame code to cycles per frame, 0 for reserved
	function automatic logic [22:0] frame_len(input logic [2:0] code);
		case (code)
			3'h0: frame_len = 23'(FRAME_CYC_0);
			3'h1: frame_len = 23'(FRAME_CYC_1);
			3'h2: frame_len = 23'(FRAME_CYC_2);
			3'h3: frame_len = 23'(FRAME_CYC_3);
			3'h4: frame_len = 23'(FRAME_CYC_4);
			3'h5: frame_len = 23'(FRAME_CYC_5);
			3'h6: frame_len = 23'(FRAME_CYC_6);
			default: frame_len = 23'h000000;
		endcase
	endfunction

	logic        ack_q;
	logic [15:0] rd_q;
	logic [15:0] page_q;
	logic [15:0] cmd_q;
	logic [1:0]  mac_mode_q;
	logic [3:0]  fast_sel_q;
	logic [15:0] led_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [NUM_MEDIA-1:0] m1000_q;
	logic [NUM_MEDIA-1:0] m100_q;
	logic        fast_q;
	logic        tick_q;
	logic        pwm_q;
	logic [22:0] frame_cnt_q;
	logic [9:0]  step_cnt_q;
	logic [7:0]  pwm_cnt_q;
	logic [15:0] exec_cnt_q;
	logic        done_q;
	logic        bad_q;
	pgcr_state_t state_q;
	pgcr_state_t state_d;
	logic [NUM_PORTS-1:0] irq_s1_q;
	logic [NUM_PORTS-1:0] irq_s2_q;
	logic [NUM_PORTS-1:0] irq_s3_q;
	logic [NUM_PORTS-1:0] lf_s1_q;
	logic [NUM_PORTS-1:0] lf_s2_q;
	logic [NUM_PORTS-1:0] caused_q;

	// bus decode
	wire         req       = wb_cyc_i & wb_stb_i;
	wire  [4:0]  idx       = wb_adr_i[6:2];
	wire         in_range  = ~wb_adr_i[7];
	wire         on_global = (page_q == PAGE_GLOBAL);
	wire         wr_fire   = req & wb_we_i & ack_q;
	wire         rd_fire   = req & ~wb_we_i & ack_q;
	wire  [15:0] wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire         sel_page  = in_range & (idx == IDX_PAGE_SEL);
	wire         sel_cmd   = in_range & on_global & (idx == IDX_CMD_WINDOW);
	wire         sel_mac   = in_range & on_global & (idx == IDX_MAC_FAST);
	wire         sel_led   = in_range & on_global & (idx == IDX_LED_CTRL);
	wire         sel_istat = in_range & on_global & (idx == IDX_IRQ_STATUS);
	wire         sel_imask = in_range & on_global & (idx == IDX_IRQ_MASK);
	wire         sel_src   = in_range & on_global & (idx == IDX_PORT_SRC);
	wire         busy      = (state_q != PGCR_IDLE);
	wire  [15:0] wr_val    = wb_dat_i[15:0];
	wire  [15:0] cmd_new   = (cmd_q & ~wmask) | (wr_val & wmask);
	// a new command while one runs is dropped: the host must wait for bit 15
	wire         cmd_wr    = wr_fire & sel_cmd & ~busy;
	wire         cmd_go    = cmd_wr & cmd_new[CMD_GO_BIT];

	// read mux; unmapped or off-page words read as zero
	wire  [15:0] cmd_view  = {busy, cmd_q[14:0]};
	wire  [15:0] mac_view  = {mac_mode_q, 10'h000, fast_sel_q};
	wire  [15:0] src_view  = {4'h0, ~caused_q};
	wire  [15:0] rd_mux    = sel_page  ? page_q :
				 sel_cmd   ? cmd_view :
				 sel_mac   ? mac_view :
				 sel_led   ? (led_q & LED_CTRL_WMASK) :
				 sel_istat ? {13'h0000, irq_stat_q} :
				 sel_imask ? {13'h0000, irq_mask_q} :
				 sel_src   ? src_view : 16'h0000;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			rd_q  <= 16'h0000;
		end else begin
			ack_q <= req & ~ack_q;
			rd_q  <= rd_mux;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = {16'h0000, rd_q};

	// page select and plain configuration registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			page_q     <= PAGE_MAIN;
			led_q      <= LED_CTRL_RST;
			fast_sel_q <= FAST_SEL_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else begin
			if (wr_fire & sel_page)
				page_q <= (page_q & ~wmask) | (wr_val & wmask);
			if (wr_fire & sel_led)
				led_q <= (led_q & ~(wmask & LED_CTRL_WMASK)) | (wr_val & wmask & LED_CTRL_WMASK);
			if (wr_fire & sel_mac & wb_sel_i[0])
				fast_sel_q <= wr_val[3:0];
			if (wr_fire & sel_imask & wb_sel_i[0])
				irq_mask_q <= wr_val[IRQ_W-1:0];
		end
	end

	// command engine: idle, run for a fixed time, then apply
	wire exec_end = (state_q == PGCR_EXEC) && (exec_cnt_q == 16'(CMD_EXEC_CYC - 1));
	always_comb begin
		state_d = state_q;
		case (state_q)
			PGCR_IDLE: if (cmd_go) state_d = PGCR_EXEC;
			PGCR_EXEC: if (exec_end) state_d = PGCR_DONE;
			PGCR_DONE: state_d = PGCR_IDLE;
			default:   state_d = PGCR_IDLE;
		endcase
	end

	// command field decode
	wire [3:0] pmask     = cmd_q[CMD_PMASK_LSB +: NUM_MEDIA];
	wire       is_media  = (cmd_q[15:12] == CMD_MEDIA_TOP);
	wire       is_1000x  = is_media & (cmd_q[7:0] == CMD_MEDIA_1000X);
	wire       is_100fx  = is_media & (cmd_q[7:0] == CMD_MEDIA_100FX);
	wire       is_sgmii  = (cmd_q == CMD_MAC_SGMII);
	wire       is_qsgmii = (cmd_q == CMD_MAC_QSGMII);
	wire       apply     = (state_q == PGCR_DONE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q    <= PGCR_IDLE;
			exec_cnt_q <= 16'h0000;
			cmd_q      <= 16'h0000;
		end else begin
			state_q    <= state_d;
			exec_cnt_q <= (state_q == PGCR_EXEC) ? exec_cnt_q + 16'h0001 : 16'h0000;
			if (cmd_wr)
				cmd_q <= cmd_new;
		end
	end

	// results of a finished command; mac mode is also written directly
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mac_mode_q <= MAC_MODE_RST;
			m1000_q    <= 4'h0;
			m100_q     <= 4'h0;
			done_q     <= 1'b0;
			bad_q      <= 1'b0;
		end else begin
			done_q <= apply;
			bad_q  <= apply & ~(is_sgmii | is_qsgmii | is_1000x | is_100fx);
			if (apply & is_sgmii)
				mac_mode_q <= MAC_MODE_SGMII;
			else if (apply & is_qsgmii)
				mac_mode_q <= MAC_MODE_RST;
			else if (wr_fire & sel_mac & wb_sel_i[1])
				mac_mode_q <= wr_val[MAC_MODE_LSB +: 2];
			// unselected upper ports keep their media setting
			if (apply & is_1000x) begin
				m1000_q <= m1000_q | pmask;
				m100_q  <= m100_q & ~pmask;
			end else if (apply & is_100fx) begin
				m100_q  <= m100_q | pmask;
				m1000_q <= m1000_q & ~pmask;
			end
		end
	end

	assign mac_sgmii_o     = (mac_mode_q == MAC_MODE_SGMII);
	assign mac_mode_rsvd_o = (mac_mode_q == MAC_MODE_RSVD);
	assign media_1000x_o   = m1000_q;
	assign media_100fx_o   = m100_q;

	// pin inputs pass two flops; the third irq stage feeds edge detect only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
			irq_s3_q <= '0;
			lf_s1_q  <= '0;
			lf_s2_q  <= '0;
		end else begin
			irq_s1_q <= port_irq_i;
			irq_s2_q <= irq_s1_q;
			irq_s3_q <= irq_s2_q;
			lf_s1_q  <= link_fail_i;
			lf_s2_q  <= lf_s1_q;
		end
	end

	// per-port source latch; a new interrupt beats a same-cycle status read
	wire [NUM_PORTS-1:0] port_rise = irq_s2_q & ~irq_s3_q;
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_src
			always_ff @(posedge core_clk) begin
				if (rst)
					caused_q[gp] <= 1'b0;
				else if (port_rise[gp])
					caused_q[gp] <= 1'b1;
				else if (port_stat_rd_i[gp])
					caused_q[gp] <= 1'b0;
			end
		end
	endgenerate

	// fast link routing; selector values above 11 switch the pin off
	wire fast_on = (fast_sel_q <= FAST_SEL_LAST);
	always_ff @(posedge core_clk) begin
		if (rst)
			fast_q <= 1'b0;
		else
			fast_q <= fast_on & lf_s2_q[fast_sel_q];
	end
	assign fast_link_o    = fast_q;
	assign fast_link_en_o = fast_on;

	// led field decode
	wire [7:0] duty_raw  = led_q[LED_DUTY_LSB +: 8];
	wire [7:0] duty      = (duty_raw > LED_DUTY_MAX) ? LED_DUTY_MAX : duty_raw;
	wire [2:0] rate      = led_q[LED_RATE_LSB +: 3];
	wire [1:0] led_sel   = led_q[LED_SEL_LSB +: 2];
	wire [22:0] flen     = frame_len(rate);
	assign led_pins_hi_en_o = led_q[LED_EN2_BIT];
	assign led_pins_lo_en_o = led_q[LED_EN1_BIT];
	assign led_per_port_o   = 3'h4 - {1'b0, led_sel};

	// frame timer; reserved code stops the stream rather than guess a rate
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frame_cnt_q <= 23'h000000;
			tick_q      <= 1'b0;
		end else if ((rate == LED_RATE_RSVD) || (frame_cnt_q >= flen - 23'h000001)) begin
			frame_cnt_q <= 23'h000000;
			tick_q      <= (rate != LED_RATE_RSVD);
		end else begin
			frame_cnt_q <= frame_cnt_q + 23'h000001;
			tick_q      <= 1'b0;
		end
	end
	assign led_frame_tick_o = tick_q;

	// pwm: 200 half-percent slots, duty n lights n+1 of them
	wire step_end = (step_cnt_q == 10'(PWM_STEP_CYC - 1));
	always_ff @(posedge core_clk) begin
		if (rst) begin
			step_cnt_q <= 10'h000;
			pwm_cnt_q  <= 8'h00;
			pwm_q      <= 1'b1;
		end else begin
			step_cnt_q <= step_end ? 10'h000 : step_cnt_q + 10'h001;
			if (step_end)
				pwm_cnt_q <= (pwm_cnt_q == LED_PWM_LAST) ? 8'h00 : pwm_cnt_q + 8'h01;
			pwm_q <= ~led_pulse_en_i | (pwm_cnt_q <= duty);
		end
	end
	assign led_pwm_o = pwm_q;

	// sticky status; a read clears only the bits it returned
	wire [IRQ_W-1:0] ev;
	assign ev[IRQ_CMD_DONE] = done_q;
	assign ev[IRQ_PORT]     = |port_rise;
	assign ev[IRQ_BAD_CMD]  = bad_q;
	wire [IRQ_W-1:0] rd_clr = (rd_fire & sel_istat) ? rd_q[IRQ_W-1:0] : '0;
	always_ff @(posedge core_clk) begin
		if (rst)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~rd_clr) | ev;
	end
	assign irq_o = |(irq_stat_q & irq_mask_q);

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_go;
		cmd_go;
	endsequence
	sequence s_run;
		busy [*8];
	endsequence

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");
	ack_answer_a: assert property ((req && !ack_q) |=> wb_ack_o)
		else $error("request not acked next cycle");
	page_gate_a: assert property ((wb_ack_o && !on_global && !wb_we_i && (idx != IDX_PAGE_SEL))
		|-> (wb_dat_o == 32'h00000000))
		else $error("global register visible off page");
	cmd_start_a: assert property (s_go |=> (state_q == PGCR_EXEC))
		else $error("command did not start");
	cmd_busy_a: assert property (s_go |=> s_run ##[1:300] !busy)
		else $error("command bit 15 did not clear in time");
	cmd_ignore_a: assert property ((wr_fire && sel_cmd && busy) |=> $stable(cmd_q))
		else $error("command window changed while busy");
	sgmii_cmd_a: assert property ((apply && is_sgmii) |=> mac_sgmii_o)
		else $error("sgmii command not applied");
	media_mask_a: assert property ((apply && is_1000x) |=>
		((media_1000x_o & $past(pmask)) == $past(pmask))
		&& ((media_1000x_o & ~$past(pmask)) == ($past(m1000_q) & ~$past(pmask))))
		else $error("media command touched an unselected port");
	fast_off_a: assert property ((fast_sel_q > FAST_SEL_LAST) |=> !fast_link_o)
		else $error("fast link driven while disabled");
	pwm_idle_a: assert property (!led_pulse_en_i |=> led_pwm_o)
		else $error("led pulsed without pulsing enable");
	src_set_a: assert property (port_rise[0] |=> (src_view[0] == 1'b0))
		else $error("port source bit not low after interrupt");
	src_clr_a: assert property ((port_stat_rd_i[0] && !port_rise[0]) |=> src_view[0])
		else $error("port source bit not restored by status read");
	stat_set_a: assert property (done_q |=> irq_stat_q[IRQ_CMD_DONE])
		else $error("command done event lost against a status read");

endmodule

/* src/pgcr_pkg.sv */
package pgcr_pkg;
	// register indices; byte address is four times the index
	localparam logic [4:0]  IDX_CMD_WINDOW   = 5'h12;
	localparam logic [4:0]  IDX_MAC_FAST     = 5'h13;
	localparam logic [4:0]  IDX_LED_CTRL     = 5'h19;
	localparam logic [4:0]  IDX_IRQ_STATUS   = 5'h1A;
	localparam logic [4:0]  IDX_IRQ_MASK     = 5'h1B;
	localparam logic [4:0]  IDX_PORT_SRC     = 5'h1D;
	localparam logic [4:0]  IDX_PAGE_SEL     = 5'h1F;
	// page select values
	localparam logic [15:0] PAGE_GLOBAL      = 16'h0010;
	localparam logic [15:0] PAGE_MAIN        = 16'h0000;
	// command window
	localparam int          CMD_GO_BIT       = 15;
	localparam logic [15:0] CMD_MAC_SGMII    = 16'h80B0;
	localparam logic [15:0] CMD_MAC_QSGMII   = 16'h80A0;
	localparam logic [7:0]  CMD_MEDIA_1000X  = 8'h81;
	localparam logic [7:0]  CMD_MEDIA_100FX  = 8'h91;
	localparam logic [3:0]  CMD_MEDIA_TOP    = 4'h8;
	localparam int          CMD_PMASK_LSB    = 8;
	// mac mode and fast link select
	localparam int          MAC_MODE_LSB     = 14;
	localparam logic [1:0]  MAC_MODE_SGMII   = 2'h1;
	localparam logic [1:0]  MAC_MODE_RSVD    = 2'h3;
	localparam logic [1:0]  MAC_MODE_RST     = 2'h0;
	localparam logic [3:0]  FAST_SEL_RST     = 4'hF;
	localparam logic [3:0]  FAST_SEL_LAST    = 4'hB;
	// led control fields
	localparam int          LED_DUTY_LSB     = 8;
	localparam int          LED_EN2_BIT      = 7;
	localparam int          LED_EN1_BIT      = 6;
	localparam int          LED_RATE_LSB     = 3;
	localparam int          LED_SEL_LSB      = 1;
	localparam logic [15:0] LED_CTRL_RST     = 16'h0000;
	localparam logic [15:0] LED_CTRL_WMASK   = 16'hFFFE;
	localparam logic [7:0]  LED_DUTY_MAX     = 8'hC6;
	localparam logic [7:0]  LED_PWM_LAST     = 8'hC7;
	localparam logic [2:0]  LED_RATE_RSVD    = 3'h7;
	// interrupt status bits
	localparam int          IRQ_CMD_DONE     = 0;
	localparam int          IRQ_PORT         = 1;
	localparam int          IRQ_BAD_CMD      = 2;
	localparam int          IRQ_W            = 3;
	localparam logic [2:0]  IRQ_MASK_RST     = 3'h0;
	// timing
	localparam int          CLK_HZ           = 200_000_000;
	localparam int          CMD_EXEC_NS      = 1000;
	localparam int          CMD_EXEC_CYC     = (CMD_EXEC_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int          PWM_STEP_CYC     = 1000;
	localparam int          FRAME_HZ_0       = 2500;
	localparam int          FRAME_HZ_1       = 1000;
	localparam int          FRAME_HZ_2       = 500;
	localparam int          FRAME_HZ_3       = 250;
	localparam int          FRAME_HZ_4       = 200;
	localparam int          FRAME_HZ_5       = 125;
	localparam int          FRAME_HZ_6       = 40;
	localparam int          NUM_PORTS        = 12;
	localparam int          NUM_MEDIA        = 4;
	// command engine states
	typedef enum logic [1:0] {
		PGCR_IDLE = 2'h0,
		PGCR_EXEC = 2'h1,
		PGCR_DONE = 2'h3
	} pgcr_state_t;
endpackage

/* testbench/pgcr_port_model.sv */
`timescale 1ns/10ps
// far-side ports: each raises its interrupt line and holds it until serviced
module pgcr_port_model
	import pgcr_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic [NUM_PORTS-1:0] raise,
	input  wire logic [NUM_PORTS-1:0] service,
	output logic      [NUM_PORTS-1:0] port_irq,
	output logic      [NUM_PORTS-1:0] stat_rd
);
	// line stays high after service too would hide a missed clear, so drop it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_irq <= '0;
			stat_rd  <= '0;
		end else begin
			port_irq <= (port_irq | raise) & ~service;
			stat_rd  <= service;
		end
	end
endmodule

/* testbench/phy_global_config_regs_bench.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module phy_global_config_regs_bench;
	import pgcr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        cyc      = 1'b0;
	logic        we       = 1'b0;
	logic        pulse_en = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [31:0] wdat     = 32'h0;
	logic [31:0] dat_o, rd;
	logic        ack, mac_sgmii, rsvd, fl, fl_en, hi_en, lo_en, tick, pwm, irq, esg, bad;
	logic [3:0]  sel      = 4'h0;
	logic [3:0]  m1k, m100, msk;
	logic [3:0]  e1k      = 4'h0;
	logic [3:0]  e100     = 4'h0;
	logic [2:0]  per;
	logic [11:0] raise    = 12'h0;
	logic [11:0] service  = 12'h0;
	logic [11:0] lfail    = 12'h0;
	logic [11:0] port_irq, stat_rd;
	logic [15:0] v;
	logic [31:0] seed     = 32'hE197;
	logic [15:0] cmds[7]  = '{16'h80B0, 16'h8F81, 16'h8391, 16'h8F91, 16'h8CC1, 16'h80A0, 16'h8123};
	int          err_count  = 0;
	int          num_checks = 0;
	int          ticks, p;

	// small frame periods keep the tick count short; the two slowest codes keep
	// their real periods, far longer than the window, so they must stay silent
	pgcr_top #(.FRAME_CYC_0(20), .FRAME_CYC_1(40), .FRAME_CYC_2(60), .FRAME_CYC_3(80),
		.FRAME_CYC_4(100)) dut_u (
		.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.port_irq_i(port_irq), .port_stat_rd_i(stat_rd), .link_fail_i(lfail),
		.led_pulse_en_i(pulse_en), .mac_sgmii_o(mac_sgmii), .mac_mode_rsvd_o(rsvd),
		.media_1000x_o(m1k), .media_100fx_o(m100), .fast_link_o(fl), .fast_link_en_o(fl_en),
		.led_pins_hi_en_o(hi_en), .led_pins_lo_en_o(lo_en), .led_per_port_o(per),
		.led_frame_tick_o(tick), .led_pwm_o(pwm), .irq_o(irq));

	pgcr_port_model port_u (.core_clk(core_clk), .rst(rst), .raise(raise), .service(service),
		.port_irq(port_irq), .stat_rd(stat_rd));

	// 200 MHz
	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h80200003 : 32'h0);
	endfunction

	// anything outside the four known command shapes must be refused
	function automatic logic cmd_bad(input logic [15:0] c);
		return !(c == CMD_MAC_SGMII || c == CMD_MAC_QSGMII || (c[15:12] == CMD_MEDIA_TOP &&
			(c[7:0] == CMD_MEDIA_1000X || c[7:0] == CMD_MEDIA_100FX)));
	endfunction

	task automatic complete_run();
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one classic cycle; request held until ack is sampled, no latency assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0, d};
		sel <= 4'h3;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_o;
		cyc <= 1'b0;
		if (n >= 50) err_count++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0, rd);
		`CHK(nm, e, rd)
	endtask

	// watchdog, far beyond the few thousand cycles the sequence needs
	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdc("offpage", 8'h48, 32'h0);
		wr(8'h7C, PAGE_GLOBAL);
		rdc("macrst", 8'h4C, 32'h000F);
		rdc("ledrst", 8'h64, 32'h0);
		rdc("srcrst", 8'h74, 32'h0FFF);
		`CHK("flenrst", 1'b0, fl_en)
		`CHK("pwmoff", 1'b1, pwm)
		// every command, a partial port mask and two unknown values
		wr(8'h6C, 16'h0001);
		foreach (cmds[i]) begin
			wr(8'h48, cmds[i]);
			bus(1'b0, 8'h48, 16'h0, rd);
			`CHK("busy", 1'b1, rd[15])
			p = 0;
			while (rd[15] !== 1'b0 && p < 400) begin
				bus(1'b0, 8'h48, 16'h0, rd);
				p++;
			end
			`CHK("done", 1'b0, rd[15])
			bad = cmd_bad(cmds[i]);
			msk = cmds[i][11:8];
			if (cmds[i] == CMD_MAC_SGMII) esg = 1'b1;
			if (cmds[i] == CMD_MAC_QSGMII) esg = 1'b0;
			if (!bad && cmds[i][7:0] == CMD_MEDIA_1000X) begin
				e1k = e1k | msk;
				e100 = e100 & ~msk;
			end
			if (!bad && cmds[i][7:0] == CMD_MEDIA_100FX) begin
				e100 = e100 | msk;
				e1k = e1k & ~msk;
			end
			repeat (2) @(posedge core_clk);
			`CHK("sgmii", esg, mac_sgmii)
			`CHK("m1k", e1k, m1k)
			`CHK("m100", e100, m100)
			`CHK("irqset", 1'b1, irq)
			rdc("cstat", 8'h68, {29'h0, bad, 2'b01});
			@(posedge core_clk);
			`CHK("irqclr", 1'b0, irq)
		end
		// mode and fast link selector, boundary values first
		for (int k = 0; k < 10; k++) begin
			seed = lfsr(seed);
			v = (k == 0) ? 16'h400B : (k == 1) ? 16'hC00C : seed[15:0];
			lfail <= seed[27:16];
			wr(8'h4C, v);
			rdc("mac", 8'h4C, {16'h0, v & 16'hC00F});
			repeat (6) @(posedge core_clk);
			`CHK("sg", v[15:14] == 2'b01, mac_sgmii)
			`CHK("rsv", v[15:14] == 2'b11, rsvd)
			`CHK("flen", v[3:0] <= 4'hB, fl_en)
			`CHK("fl", v[3:0] <= 4'hB && lfail[v[3:0]], fl)
		end
		// led control across all eight rate codes; bit 0 written 1 must read 0
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			v = {8'(seed[7:0] % 199), seed[9:8], 3'(k), seed[11:10], 1'b1};
			pulse_en <= seed[12];
			wr(8'h64, v);
			rdc("led", 8'h64, {16'h0, v & 16'hFFFE});
			`CHK("hi", v[7], hi_en)
			`CHK("lo", v[6], lo_en)
			`CHK("per", 3'h4 - v[2:1], per)
			ticks = 0;
			repeat (300) begin
				@(posedge core_clk);
				ticks += tick;
			end
			p = (k >= 5) ? 0 : 300 / (20 + 20 * k);
			`CHK("tick", 1'b1, (p == 0) ? ticks == 0 : (ticks <= p + 1 && ticks + 1 >= p))
			if (!seed[12]) `CHK("pwm", 1'b1, pwm)
		end
		// port sources, serviced through the far-side model
		wr(8'h6C, 16'h0002);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			p = (k == 0) ? 0 : int'(seed % 12); // port 0 first, watched by the source checks
			raise[p] <= 1'b1;
			@(posedge core_clk);
			raise <= 12'h0;
			repeat (8) @(posedge core_clk);
			rdc("src", 8'h74, {20'h0, ~(12'h1 << p)});
			`CHK("pirq", 1'b1, irq)
			rdc("pstat", 8'h68, 32'h2);
			service[p] <= 1'b1;
			@(posedge core_clk);
			service <= 12'h0;
			repeat (4) @(posedge core_clk);
			rdc("srcclr", 8'h74, 32'h0FFF);
		end
		// unmapped space, then back to the main page hides the global set
		wr(8'h80, 16'hFFFF);
		rdc("unmap", 8'h80, 32'h0);
		wr(8'h7C, PAGE_MAIN);
		rdc("mainpg", 8'h4C, 32'h0);
		complete_run();
	end
endmodule
